/* include/cub_defines.vh */
`ifndef CUB_DEFINES_VH
`define CUB_DEFINES_VH
// current samples: unsigned, rated current In = CUB_RATED counts
`define CUB_IW 16
`define CUB_RATED 16'd1000
// 10 % and 150 % of rated current
`define CUB_LO_LIM 16'd100
`define CUB_HI_LIM 16'd1500
// start current difference setting, percent
`define CUB_DIFF_MIN 7'd10
`define CUB_DIFF_MAX 7'd90
`define CUB_DIFF_DEF 7'd50
// trip delay setting, milliseconds
`define CUB_DLY_MIN 16'd100
`define CUB_DLY_MAX 16'd60000
`define CUB_DLY_DEF 16'd100
// clock 50 MHz: cycles per millisecond
`define CUB_CLK_KHZ 50000
`define CUB_MS_CYC 16'd50000
// event codes
`define CUB_EV_START 1'b0
`define CUB_EV_TRIP 1'b1
`endif

/* hdl/cub_tick.v */
`timescale 1ns/1ps
`include "cub_defines.vh"
// millisecond tick; restarts when clr is high so the first tick is a full ms
module cub_tick
#(
    parameter [15:0] CYC_PER_MS = `CUB_MS_CYC
)
(
    input wire clk, // clock
    input wire sys_rst, // async reset
    input wire clr, // restart the interval
    output reg tick_q // one-cycle pulse each ms
);
    reg [15:0] cnt_q;
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (clr)
        begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (cnt_q == CYC_PER_MS - 16'h0001)
        begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end
endmodule // cub_tick

/* hdl/cub_unbalance.v */
`timescale 1ns/1ps
`include "cub_defines.vh"
module cub_unbalance
#(
    parameter [15:0] CYC_PER_MS = `CUB_MS_CYC
)
(
    input wire clk, // 50 MHz clock
    input wire sys_rst, // async reset, high
    input wire sample_valid, // new phase values present
    input wire [`CUB_IW-1:0] phase1_rms, // phase 1 fundamental rms
    input wire [`CUB_IW-1:0] phase2_rms, // phase 2 fundamental rms
    input wire [`CUB_IW-1:0] phase3_rms, // phase 3 fundamental rms
    input wire operation_on, // operation setting, 0 = Off
    input wire start_only, // start signal only setting
    input wire [6:0] diff_setting, // start current difference, percent
    input wire [15:0] delay_ms, // trip delay, ms
    input wire block_input, // user-logic blocking
    output reg general_start_out, // general start
    output reg general_trip_out, // general trip
    output reg event_valid, // one-cycle event strobe
    output reg event_id, // 0 start, 1 trip
    output reg event_value, // new value, 1 = on
    output reg current_sufficient, // max above 10 percent In
    output reg current_not_fault // max below 150 percent In
);
    localparam EV_IDLE = 1'b0;
    localparam EV_TRIP_DUE = 1'b1;

    reg [`CUB_IW-1:0] max_q;
    reg [`CUB_IW-1:0] min_q;
    reg unbal_q;
    reg [6:0] diff_eff;
    reg [15:0] dly_eff;
    reg [15:0] ms_q;
    reg start_d;
    reg trip_d;
    reg ev_state_q;
    wire tick;
    wire enabled;
    wire [`CUB_IW-1:0] max_d;
    wire [`CUB_IW-1:0] min_d;
    wire [3*`CUB_IW-1:0] phase_all;
    wire [4*`CUB_IW-1:0] max_chain;
    wire [4*`CUB_IW-1:0] min_chain;
    wire [`CUB_IW+6:0] lhs;
    wire [`CUB_IW+6:0] rhs;
    genvar g;

    assign enabled = operation_on & ~block_input;

    // phases packed so the max/min chain is one loop over channels
    assign phase_all = {phase3_rms, phase2_rms, phase1_rms};
    assign max_chain[`CUB_IW-1:0] = {`CUB_IW{1'b0}};
    assign min_chain[`CUB_IW-1:0] = {`CUB_IW{1'b1}};

    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_phase
            wire [`CUB_IW-1:0] ph;
            wire [`CUB_IW-1:0] mx_in;
            wire [`CUB_IW-1:0] mn_in;
            assign ph = phase_all[g*`CUB_IW +: `CUB_IW];
            assign mx_in = max_chain[g*`CUB_IW +: `CUB_IW];
            assign mn_in = min_chain[g*`CUB_IW +: `CUB_IW];
            assign max_chain[(g+1)*`CUB_IW +: `CUB_IW] =
                (ph > mx_in) ? ph : mx_in;
            assign min_chain[(g+1)*`CUB_IW +: `CUB_IW] =
                (ph < mn_in) ? ph : mn_in;
        end
    endgenerate

    assign max_d = max_chain[3*`CUB_IW +: `CUB_IW];
    assign min_d = min_chain[3*`CUB_IW +: `CUB_IW];

    // out-of-range settings clamp to the nearest limit
    always @*
    begin
        if (diff_setting < `CUB_DIFF_MIN)
        begin
            diff_eff = `CUB_DIFF_MIN;
        end
        else if (diff_setting > `CUB_DIFF_MAX)
        begin
            diff_eff = `CUB_DIFF_MAX;
        end
        else
        begin
            diff_eff = diff_setting;
        end
    end

    // a zero delay would let trip follow start at once
    always @*
    begin
        if (delay_ms < `CUB_DLY_MIN)
        begin
            dly_eff = `CUB_DLY_MIN;
        end
        else if (delay_ms > `CUB_DLY_MAX)
        begin
            dly_eff = `CUB_DLY_MAX;
        end
        else
        begin
            dly_eff = delay_ms;
        end
    end

    // 100*(max-min) > diff*max, done in integers to avoid a divider
    assign lhs = {7'h00, max_q - min_q} * 23'd100;
    assign rhs = {7'h00, max_q} * {16'h0000, diff_eff};

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            max_q <= {`CUB_IW{1'b0}};
            min_q <= {`CUB_IW{1'b0}};
            current_sufficient <= 1'b0;
            current_not_fault <= 1'b0;
        end
        else if (sample_valid)
        begin
            max_q <= max_d;
            min_q <= min_d;
            current_sufficient <= (max_d > `CUB_LO_LIM);
            current_not_fault <= (max_d < `CUB_HI_LIM);
        end
    end

    // settings act on the held sample, so a changed limit applies at once
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            unbal_q <= 1'b0;
        end
        else
        begin
            unbal_q <= (lhs > rhs);
        end
    end

    always @*
    begin
        start_d = enabled & unbal_q & current_sufficient
            & current_not_fault;
        // delay counts from start, which is itself one sample late;
        // the settable range hides that few-cycle algorithm time
        trip_d = start_d & ~start_only
            & ((ms_q >= dly_eff) | general_trip_out);
    end

    cub_tick #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(~start_d),
        .tick_q(tick)
    );

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ms_q <= 16'h0000;
        end
        else if (~start_d)
        begin
            ms_q <= 16'h0000;
        end
        else if (tick && ms_q != 16'hffff)
        begin
            ms_q <= ms_q + 16'h0001;
        end
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            general_start_out <= 1'b0;
            general_trip_out <= 1'b0;
        end
        else
        begin
            general_start_out <= start_d;
            general_trip_out <= trip_d;
        end
    end

    // one event per cycle: when start and trip change together the
    // trip event waits and then reports the settled trip level
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ev_state_q <= EV_IDLE;
            event_valid <= 1'b0;
            event_id <= `CUB_EV_START;
            event_value <= 1'b0;
        end
        else
        begin
            case (ev_state_q)
                EV_IDLE:
                begin
                    if (start_d != general_start_out)
                    begin
                        event_valid <= 1'b1;
                        event_id <= `CUB_EV_START;
                        event_value <= start_d;
                        if (trip_d != general_trip_out)
                        begin
                            ev_state_q <= EV_TRIP_DUE;
                        end
                    end
                    else if (trip_d != general_trip_out)
                    begin
                        event_valid <= 1'b1;
                        event_id <= `CUB_EV_TRIP;
                        event_value <= trip_d;
                    end
                    else
                    begin
                        event_valid <= 1'b0;
                    end
                end
                EV_TRIP_DUE:
                begin
                    if (start_d != general_start_out)
                    begin
                        event_valid <= 1'b1;
                        event_id <= `CUB_EV_START;
                        event_value <= start_d;
                    end
                    else
                    begin
                        event_valid <= 1'b1;
                        event_id <= `CUB_EV_TRIP;
                        event_value <= general_trip_out;
                        if (trip_d == general_trip_out)
                        begin
                            ev_state_q <= EV_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule // cub_unbalance

/* verification/cub_src.sv */
`timescale 1ns/1ps
module cub_src (
    input wire clk, // sample clock
    output logic sample_valid, // new rms set
    output logic [15:0] phase1_rms, // phase 1 rms
    output logic [15:0] phase2_rms, // phase 2 rms
    output logic [15:0] phase3_rms // phase 3 rms
);
// a new set only every 4th cycle, as a slow fourier stage would
logic [1:0] cnt_q = 2'h0;
initial {sample_valid, phase1_rms, phase2_rms, phase3_rms} = 49'h0;
always @(posedge clk)
begin
    cnt_q <= #1 cnt_q + 2'h1;
    sample_valid <= #1 (cnt_q == 2'h3);
end
task set(input logic [15:0] a, b, c);
    @(posedge clk);
    #1 {phase1_rms, phase2_rms, phase3_rms} = {a, b, c};
endtask
endmodule // cub_src

/* verification/cub_unbalance_chk.sv */
`timescale 1ns/1ps
module cub_unbalance_chk (
    input wire clk, // sample clock
    input wire sys_rst, // async reset, high
    input wire sample_valid, // new phase set
    input wire operation_on, // operation setting
    input wire start_only, // start only setting
    input wire block_input, // user blocking
    input wire general_start_out, // general start
    input wire general_trip_out, // general trip
    input wire event_valid, // event strobe
    input wire event_id, // 0 start, 1 trip
    input wire event_value, // new value
    input wire current_sufficient, // max above 10 percent
    input wire current_not_fault, // max below 150 percent
    input wire [15:0] phase1_rms, // phase 1 rms
    input wire [15:0] phase2_rms, // phase 2 rms
    input wire [15:0] phase3_rms // phase 3 rms
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [15:0] m12 = phase1_rms > phase2_rms ? phase1_rms : phase2_rms;
    wire [15:0] mx = m12 > phase3_rms ? m12 : phase3_rms;
    sequence s_ev(id, val);
        event_valid && event_id == id && event_value == val;
    endsequence
    a_off_no_start: assert property (
        !operation_on |=> !general_start_out)
        else $error("start while off");
    a_blk_no_trip: assert property (
        block_input |=> !general_trip_out)
        else $error("trip while blocked");
    a_only_no_trip: assert property (
        start_only |=> !general_trip_out)
        else $error("trip in start only mode");
    a_trip_with_start: assert property (
        general_trip_out |-> general_start_out)
        else $error("trip without start");
    a_start_event: assert property (
        $rose(general_start_out) |-> ##[0:1] s_ev(0, 1))
        else $error("no start on event");
    a_stop_event: assert property (
        $fell(general_start_out) |-> s_ev(0, 0))
        else $error("no start off event");
    a_trip_event: assert property (
        $fell(general_trip_out) |-> ##[0:2] s_ev(1, 0))
        else $error("no trip off event");
    a_trip_on_event: assert property (
        $rose(general_trip_out) |-> ##[0:1] s_ev(1, 1))
        else $error("no trip on event");
    a_level_flags: assert property (sample_valid |=>
        current_sufficient == ($past(mx) > 16'h0064) &&
        current_not_fault == ($past(mx) < 16'h05dc))
        else $error("current flags wrong");
    a_start_enabled: assert property ($rose(general_start_out)
        |-> $past(operation_on && !block_input))
        else $error("start while disabled");
endmodule // cub_unbalance_chk
bind cub_unbalance cub_unbalance_chk i_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(sample_valid),
    .operation_on(operation_on),
    .start_only(start_only),
    .block_input(block_input),
    .general_start_out(general_start_out),
    .general_trip_out(general_trip_out),
    .event_valid(event_valid),
    .event_id(event_id),
    .event_value(event_value),
    .current_sufficient(current_sufficient),
    .current_not_fault(current_not_fault),
    .phase1_rms(phase1_rms),
    .phase2_rms(phase2_rms),
    .phase3_rms(phase3_rms)
);

/* verification/cub_unbalance_tb.sv */
`timescale 1ns/1ps
module cub_unbalance_tb;
logic clk = 0, sys_rst = 1, operation_on = 0, start_only = 0;
logic block_input = 0, sample_valid, event_valid, event_id, event_value;
logic general_start_out, general_trip_out;
logic current_sufficient, current_not_fault;
logic [6:0] diff_setting = 7'h32;
logic [15:0] delay_ms = 16'h0064, phase1_rms, phase2_rms, phase3_rms;
int error_cnt = 0, num_checks = 0, n;
cub_unbalance #(
    .CYC_PER_MS(16'h000a)
) i_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(sample_valid),
    .phase1_rms(phase1_rms),
    .phase2_rms(phase2_rms),
    .phase3_rms(phase3_rms),
    .operation_on(operation_on),
    .start_only(start_only),
    .diff_setting(diff_setting),
    .delay_ms(delay_ms),
    .block_input(block_input),
    .general_start_out(general_start_out),
    .general_trip_out(general_trip_out),
    .event_valid(event_valid),
    .event_id(event_id),
    .event_value(event_value),
    .current_sufficient(current_sufficient),
    .current_not_fault(current_not_fault)
);
cub_src i_src (
    .clk(clk),
    .sample_valid(sample_valid),
    .phase1_rms(phase1_rms),
    .phase2_rms(phase2_rms),
    .phase3_rms(phase3_rms)
);
initial forever #10 clk = ~clk;
task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("unexpected at %0t: got %b", $time, got);
    end
endtask
task wait_trip();
    n = 0;
    while (general_trip_out !== 1'b1)
    begin
        @(posedge clk);
        #1 n++;
        if (n > 1100)
        begin
            chk(1'b0, 1'b1);
            print_verdict();
        end
    end
endtask
task run(input logic [15:0] a, b, c, input int cyc, input logic st, tr);
    i_src.set(a, b, c);
    repeat (cyc) @(posedge clk);
    #1 chk(general_start_out, st);
    chk(general_trip_out, tr);
    $display("test done at %0t", $time);
endtask
initial
begin
    repeat (10) @(posedge clk);
    #1 sys_rst = 0;
    run(16'h03e8, 16'h03e8, 16'h0190, 12, 0, 0);
    operation_on = 1;
    run(16'h03e8, 16'h03e8, 16'h0190, 12, 1, 0);
    chk(current_sufficient & current_not_fault, 1);
    // below the floor: must still wait the 100 ms minimum
    delay_ms = 16'h0000;
    wait_trip();
    chk(n > 970 && n < 1000, 1);
    chk(event_valid & event_id & event_value, 1);
    // exactly 60 percent is not above a 60 setting
    diff_setting = 7'h3c;
    run(16'h03e8, 16'h03e8, 16'h0190, 8, 0, 0);
    diff_setting = 7'h00;
    run(16'h03e8, 16'h03e8, 16'h03b6, 12, 0, 0);
    diff_setting = 7'h32;
    run(16'h0064, 16'h0064, 16'h0000, 12, 0, 0);
    run(16'h0065, 16'h0065, 16'h0000, 12, 1, 0);
    run(16'h05dc, 16'h0000, 16'h0000, 12, 0, 0);
    run(16'h05db, 16'h0000, 16'h0000, 12, 1, 0);
    block_input = 1;
    run(16'h05db, 16'h0000, 16'h0000, 4, 0, 0);
    block_input = 0;
    start_only = 1;
    run(16'h05db, 16'h0000, 16'h0000, 1100, 1, 0);
    print_verdict();
end
endmodule // cub_unbalance_tb
